//--- rtl/dsap_pkg.sv
// Constants for the slave access port of the DMA controller.
// Assumes one 20 MHz bus clock; all values are named here once.
package dsap_pkg;
  // Target decode of {target_decode_hi, target_decode_lo}
  localparam logic [1:0] TGT_ID  = 2'h0;
  localparam logic [1:0] TGT_INT = 2'h1;
  localparam logic [1:0] TGT_DCH = 2'h2;
  localparam logic [1:0] TGT_ECH = 2'h3;

  // Bus acknowledge codes, active low on the wire
  localparam logic [2:0] ACK_IDLE  = 3'h7;
  localparam logic [2:0] ACK_ERR   = 3'h6;
  localparam logic [2:0] ACK_BYTE  = 3'h5;
  localparam logic [2:0] ACK_RERUN = 3'h4;
  localparam logic [2:0] ACK_WORD  = 3'h3;
  localparam logic [2:0] ACK_HALF  = 3'h1;

  // Transfer size codes from the master
  localparam logic [2:0] SIZ_WORD = 3'h0;
  localparam logic [2:0] SIZ_BYTE = 3'h1;
  localparam logic [2:0] SIZ_HALF = 3'h2;

  // Peripheral strobe timing
  localparam int CLK_NS        = 50;
  localparam int STROBE_NS     = 100;
  localparam int STROBE_CYC    = (STROBE_NS + CLK_NS - 1) / CLK_NS;
  localparam int SLOW_EXTRA    = 2;
  localparam logic [3:0] STROBE_CNT = 4'(STROBE_CYC);
  localparam logic [3:0] SLOW_CNT   = 4'(STROBE_CYC + SLOW_EXTRA);

  // Reset values
  localparam logic [31:0] REG_RST = 32'h0000_0000;
  localparam logic [2:0]  SIZ_W   = 3'h3;

  typedef enum logic [2:0] {
    ST_IDLE   = 3'h0,
    ST_DECODE = 3'h1,
    ST_STROBE = 3'h3,
    ST_ACK    = 3'h2,
    ST_WAIT   = 3'h6,
    ST_DRAIN  = 3'h4
  } dsap_state_type;
endpackage : dsap_pkg

//--- rtl/dsap_sync.sv
// Two-stage synchroniser for a bundle of pin inputs.
// Assumes inputs are asynchronous to clk_i; only stage two is read.
`timescale 1ns/10ps
module dsap_sync #(
  parameter int WIDTH = 1
) (
  input  wire logic             clk_i,
  input  wire logic             rst_n_i,
  input  wire logic [WIDTH-1:0] rst_val_i,
  input  wire logic [WIDTH-1:0] d_i,
  output logic      [WIDTH-1:0] q_o
);
  logic [WIDTH-1:0] meta_ff;

  // Reset value is a tie-off constant from the parent
  always_ff @(posedge clk_i) begin
    if (!rst_n_i) begin
      meta_ff <= rst_val_i;
      q_o     <= rst_val_i;
    end else begin
      meta_ff <= d_i;
      q_o     <= meta_ff;
    end
  end
endmodule : dsap_sync

//--- rtl/dsap_top.sv
// Slave access port: decodes bus slave cycles into ID, internal
// registers, D channel byte registers and E channel halfword registers.
// Assumes the DMA engines sit outside and report pack/unpack use.
//
// Overview of operation
// - Two high address bits pick one target
// - ID access returns the 32-bit ID value
// - With PROM, ID reads one byte over D bus
// - Internal access moves full word, PA[3:2] picks
// - PA[3:1] selects register within group
// - D channel registers: byte size, unbuffered
// - D channel: chip select plus read/write strobe
// - E channel registers: halfword size, unbuffered
// - E channel: chip select plus read control
// - Drain unpack register until empty
// - Acknowledge code matches target port width (byte D/PROM, half E, word ID/internal)
// - Rerun while a channel uses pack/unpack
// - Bus request low; master only after grant
// - Open-drain interrupt on completion or error
// - Read/write line: high read, low write
// - Reset initialises all internal state
// - D read strobe: register read, PROM read or DMA ack
// - D write strobe: register write or DMA ack
// - Pulled-high select pin means PROM present
// - Slow input adds two clocks to D cycles
`timescale 1ns/10ps
module dsap_top
  import dsap_pkg::*;
#(
  parameter logic [31:0] ID_VALUE = 32'h1234_5678  // Arbitrary value
) (
  input  wire logic        clk_i,
  input  wire logic        rst_n_i,
  input  wire logic        sel_n_i,
  input  wire logic        as_n_i,
  input  wire logic [3:1]  pa_i,
  input  wire logic        target_decode_hi_i,
  input  wire logic        target_decode_lo_i,
  input  wire logic        rd_i,
  input  wire logic [2:0]  siz_i,
  input  wire logic [31:0] d_i,
  output logic      [31:0] d_o,
  output logic             d_oe_o,
  output logic      [2:0]  ack_n_o,
  output logic             ack_oe_o,
  output logic             br_n_o,
  output logic             br_oe_o,
  input  wire logic        bg_n_i,
  output logic             bus_granted_o,
  output logic             intreq_n_o,
  output logic             intreq_oe_o,
  input  wire logic        lerr_n_i,
  output logic             late_err_o,
  output logic      [1:0]  late_err_tgt_o,
  input  wire logic [7:0]  dd_i,
  output logic      [7:0]  dd_o,
  output logic             dd_oe_o,
  output logic      [3:1]  dch_addr_o,
  output logic             d_cs_n_o,
  output logic             d_rd_n_o,
  output logic             d_wr_n_o,
  input  wire logic        d_irq_n_i,
  output logic             d_irq_o,
  input  wire logic        d_req_i,
  output logic             d_req_o,
  input  wire logic        slow_n_i,
  input  wire logic        prom_select_i,
  output logic             prom_select_o,
  output logic             prom_select_oe_o,
  output logic             prom_present_o,
  input  wire logic [15:0] e_ad_i,
  output logic      [15:0] e_ad_o,
  output logic             e_ad_oe_o,
  output logic             e_cs_n_o,
  output logic             e_read_o,
  input  wire logic        pack_busy_d_i,
  input  wire logic        pack_busy_e_i,
  input  wire logic        unpack_valid_i,
  output logic             unpack_pop_o,
  input  wire logic        bus_want_i,
  input  wire logic        dma_dack_i,
  input  wire logic        dma_mem_write_i,
  input  wire logic        xfer_done_i,
  input  wire logic        xfer_err_i,
  output logic      [127:0] regs_o
);
  import dsap_pkg::*;

  //////////////////////////////////////////////////////////////////////
  // Pin synchronisation
  localparam int SW = 73;
  localparam logic [SW-1:0] SYNC_RST = {2'h3, 5'h00, 1'h1, SIZ_W,
                                        32'h0, 1'h1, 1'h1, 1'h1, 1'h0,
                                        8'h00, 16'h0000, 1'h1, 1'h0};
  logic [SW-1:0] sync_q;
  logic          sel_s, as_s, rd_s, bg_s, lerr_s, dirq_s, dreq_s;
  logic          slow_s, prom_s;
  logic [3:1]    pa_s;
  logic [1:0]    tgt_s;
  logic [2:0]    siz_s;
  logic [31:0]   dat_s;
  logic [7:0]    dd_s;
  logic [15:0]   ead_s;

  dsap_sync #(.WIDTH(SW)) u_sync (
    .clk_i     (clk_i),
    .rst_n_i   (rst_n_i),
    .rst_val_i (SYNC_RST),
    .d_i       ({sel_n_i, as_n_i, pa_i, target_decode_hi_i,
                 target_decode_lo_i, rd_i, siz_i, d_i, bg_n_i, lerr_n_i,
                 d_irq_n_i, d_req_i, dd_i, e_ad_i, slow_n_i,
                 prom_select_i}),
    .q_o       (sync_q)
  );

  assign {sel_s, as_s, pa_s, tgt_s, rd_s, siz_s, dat_s, bg_s, lerr_s,
          dirq_s, dreq_s, dd_s, ead_s, slow_s, prom_s} = sync_q;

  //////////////////////////////////////////////////////////////////////
  // Decode
  dsap_state_type state_ff, nxt_state;
  logic [1:0]  tgt_ff;
  logic        rd_ff;
  logic [3:1]  pa_ff;
  logic [3:0]  cnt_ff;
  logic [1:0]  strap_cnt_ff;
  logic        lerr_d_ff;
  logic [31:0] reg_ff [4];

  wire access_w   = !sel_s && !as_s;
  wire busy_w     = pack_busy_d_i || pack_busy_e_i;
  wire is_read_w  = rd_s;
  wire size_ok_w  = (tgt_s == TGT_DCH) ? (siz_s == SIZ_BYTE) :
                    (tgt_s == TGT_ECH) ? (siz_s == SIZ_HALF) :
                    1'b1;
  wire use_prom_w = (tgt_s == TGT_ID) && prom_present_o;
  wire d_side_w   = (tgt_ff == TGT_DCH) || (tgt_ff == TGT_ID);
  wire [3:0] slen_w = (d_side_w && !slow_s) ? SLOW_CNT
                                            : STROBE_CNT;
  wire strobe_end_w = (state_ff == ST_STROBE) && (cnt_ff == 4'h1);
  wire [1:0] widx_w = pa_s[3:2];
  wire lerr_fall_w  = lerr_d_ff && !lerr_s;

  // Ack code for the access as decoded
  wire [2:0] ack_code_w =
    busy_w                 ? ACK_RERUN :
    !size_ok_w             ? ACK_ERR   :
    (tgt_s == TGT_DCH)     ? ACK_BYTE  :
    (tgt_s == TGT_ECH)     ? ACK_HALF  :
    use_prom_w             ? ACK_BYTE  :
                             ACK_WORD;

  //////////////////////////////////////////////////////////////////////
  // State machine
  always_comb begin
    nxt_state = state_ff;
    case (state_ff)
      ST_IDLE: begin
        if (access_w && busy_w)
          nxt_state = ST_ACK;
        else if (access_w && unpack_valid_i)
          nxt_state = ST_DRAIN;
        else if (access_w)
          nxt_state = ST_DECODE;
      end
      ST_DRAIN: begin
        if (!unpack_valid_i)
          nxt_state = ST_DECODE;
      end
      ST_DECODE: begin
        if (size_ok_w && ((tgt_s == TGT_DCH) || (tgt_s == TGT_ECH) ||
            use_prom_w))
          nxt_state = ST_STROBE;
        else
          nxt_state = ST_ACK;
      end
      ST_STROBE: begin
        if (cnt_ff == 4'h1)
          nxt_state = ST_ACK;
      end
      ST_ACK: nxt_state = ST_WAIT;
      ST_WAIT: begin
        if (sel_s)
          nxt_state = ST_IDLE;
      end
      default: nxt_state = ST_IDLE;
    endcase
  end

  // Error/size ack is latched in the decode step; rerun ack goes out straight from idle
  logic [2:0] ack_pend_ff;

  always_ff @(posedge clk_i) begin
    if (!rst_n_i) begin
      state_ff    <= ST_IDLE;
      tgt_ff      <= TGT_ID;
      rd_ff       <= 1'b1;
      pa_ff       <= 3'h0;
      cnt_ff      <= 4'h0;
      ack_pend_ff <= ACK_IDLE;
    end else begin
      state_ff <= nxt_state;
      if ((state_ff == ST_IDLE && access_w) || state_ff == ST_DECODE)
        ack_pend_ff <= ack_code_w;
      if (state_ff == ST_IDLE && access_w) begin
        tgt_ff <= tgt_s;
        rd_ff  <= is_read_w;
        pa_ff  <= pa_s;
      end
      if (state_ff == ST_DECODE)
        cnt_ff <= slen_w + 4'h1;
      else if (cnt_ff != 4'h0)
        cnt_ff <= cnt_ff - 4'h1;
    end
  end

  //////////////////////////////////////////////////////////////////////
  // Internal registers and bus data
  wire dec_w   = (state_ff == ST_DECODE) && size_ok_w && !busy_w;
  wire [2:0] ack_sel_w = (state_ff == ST_IDLE) ? ack_code_w : ack_pend_ff;
  wire reg_w   = dec_w && (tgt_s == TGT_INT);
  wire [31:0] rd_word_w = (tgt_s == TGT_ID) ? ID_VALUE
                                            : reg_ff[widx_w];
  wire [31:0] strobe_rd_w = (tgt_ff == TGT_ECH) ? {ead_s, ead_s}
                                                : {4{dd_s}};

  for (genvar gi = 0; gi < 4; gi++) begin : g_reg
    always_ff @(posedge clk_i) begin
      if (!rst_n_i)
        reg_ff[gi] <= REG_RST;
      else if (reg_w && !rd_s && widx_w == 2'(gi))
        reg_ff[gi] <= dat_s;
    end
    assign regs_o[gi*32 +: 32] = reg_ff[gi];
  end

  always_ff @(posedge clk_i) begin
    if (!rst_n_i) begin
      d_o      <= 32'h0;
      d_oe_o   <= 1'b0;
      ack_n_o  <= ACK_IDLE;
      ack_oe_o <= 1'b0;
    end else begin
      if (dec_w && rd_s && !use_prom_w && (tgt_s == TGT_ID ||
          tgt_s == TGT_INT))
        d_o <= rd_word_w;
      else if (strobe_end_w && rd_ff)
        d_o <= strobe_rd_w;
      d_oe_o   <= (nxt_state == ST_ACK) && rd_ff
                  && ack_sel_w != ACK_RERUN;
      ack_n_o  <= (nxt_state == ST_ACK) ? ack_sel_w : ACK_IDLE;
      ack_oe_o <= (nxt_state == ST_ACK);
    end
  end

  //////////////////////////////////////////////////////////////////////
  // Peripheral strobes
  // Strobe drops one count early so read data clears the synchroniser
  wire in_strobe_w = (nxt_state == ST_STROBE) &&
                     (state_ff == ST_DECODE || cnt_ff > 4'h2);
  wire dcyc_w  = in_strobe_w && (tgt_ff == TGT_DCH);
  wire pcyc_w  = in_strobe_w && (tgt_ff == TGT_ID);
  wire ecyc_w  = in_strobe_w && (tgt_ff == TGT_ECH);
  wire dma_rd_w = dma_dack_i && dma_mem_write_i;
  wire dma_wr_w = dma_dack_i && !dma_mem_write_i;

  always_ff @(posedge clk_i) begin
    if (!rst_n_i) begin
      dd_o             <= 8'h00;
      dd_oe_o          <= 1'b0;
      dch_addr_o       <= 3'h0;
      d_cs_n_o         <= 1'b1;
      d_rd_n_o         <= 1'b1;
      d_wr_n_o         <= 1'b1;
      e_ad_o           <= 16'h0000;
      e_ad_oe_o        <= 1'b0;
      e_cs_n_o         <= 1'b1;
      e_read_o         <= 1'b0;
      prom_select_o    <= 1'b0;
      prom_select_oe_o <= 1'b0;
      unpack_pop_o     <= 1'b0;
    end else begin
      dd_o       <= dat_s[31:24];
      dd_oe_o    <= dcyc_w && !rd_ff;
      dch_addr_o <= pa_ff;
      d_cs_n_o   <= !dcyc_w;
      d_rd_n_o   <= !((dcyc_w && rd_ff) || pcyc_w || dma_rd_w);
      d_wr_n_o   <= !((dcyc_w && !rd_ff) || dma_wr_w);
      e_ad_o     <= dat_s[31:16];
      e_ad_oe_o  <= ecyc_w && !rd_ff;
      e_cs_n_o   <= !ecyc_w;
      e_read_o   <= ecyc_w && rd_ff;
      prom_select_o    <= 1'b0;
      prom_select_oe_o <= pcyc_w;
      unpack_pop_o <= (nxt_state == ST_DRAIN) && unpack_valid_i;
    end
  end

  //////////////////////////////////////////////////////////////////////
  // Bus request, interrupt, late error, strap
  always_ff @(posedge clk_i) begin
    if (!rst_n_i) begin
      br_n_o         <= 1'b1;
      br_oe_o        <= 1'b0;
      bus_granted_o  <= 1'b0;
      intreq_n_o     <= 1'b0;
      intreq_oe_o    <= 1'b0;
      late_err_o     <= 1'b0;
      late_err_tgt_o <= TGT_ID;
      lerr_d_ff      <= 1'b1;
      d_irq_o        <= 1'b0;
      d_req_o        <= 1'b0;
      strap_cnt_ff   <= 2'h0;
      prom_present_o <= 1'b0;
    end else begin
      br_n_o        <= !bus_want_i;
      br_oe_o       <= 1'b1;
      bus_granted_o <= bus_want_i && !bg_s;
      intreq_n_o    <= 1'b0;
      intreq_oe_o   <= xfer_done_i || xfer_err_i;
      lerr_d_ff     <= lerr_s;
      // Late error lands after the cycle; blame the last target
      late_err_o    <= lerr_fall_w;
      if (lerr_fall_w)
        late_err_tgt_o <= tgt_ff;
      d_irq_o <= !dirq_s;
      d_req_o <= dreq_s;
      // Strap caught once the synchroniser holds the pin, not its reset
      if (strap_cnt_ff != 2'h3)
        strap_cnt_ff <= strap_cnt_ff + 2'h1;
      if (strap_cnt_ff == 2'h2)
        prom_present_o <= prom_s;
    end
  end
endmodule : dsap_top

//--- sim/dsap_chk.sv
// Pin-level assertions for the slave access port.
// Assumes one bus clock and its synchronous active-low reset.
`timescale 1ns/10ps
module dsap_chk
  import dsap_pkg::*;
(
  input wire logic       clk_i,
  input wire logic       rst_n_i,
  input wire logic       ack_oe_o,
  input wire logic [2:0] ack_n_o,
  input wire logic       d_cs_n_o,
  input wire logic       d_rd_n_o,
  input wire logic       d_wr_n_o,
  input wire logic       e_cs_n_o,
  input wire logic       dma_dack_i,
  input wire logic       dma_mem_write_i,
  input wire logic       bus_want_i,
  input wire logic       br_n_o,
  input wire logic       bg_n_i,
  input wire logic       bus_granted_o,
  input wire logic       slow_n_i
);
  default clocking cb @(posedge clk_i); endclocking
  default disable iff (!rst_n_i);
  // Counts select cycles; a repetition cannot take the slow figure
  logic [3:0] cs_cnt_ff;
  always_ff @(posedge clk_i) begin
    cs_cnt_ff <= (!rst_n_i || d_cs_n_o) ? 4'h0 : cs_cnt_ff + 4'h1;
  end
  ////////////////////////////////////////////////////////////////
  ack_pulse_a: assert property (ack_oe_o |=> !ack_oe_o)
    else $error("ack held over one cycle");
  d_end_byte_a: assert property ($rose(d_cs_n_o) |=>
    ack_oe_o && ack_n_o == ACK_BYTE) else $error("D cycle end bad");
  e_end_half_a: assert property ($rose(e_cs_n_o) |=>
    ack_oe_o && ack_n_o == ACK_HALF) else $error("E cycle end bad");
  d_one_strobe_a: assert property (!d_cs_n_o |-> d_rd_n_o != d_wr_n_o)
    else $error("D select without one strobe");
  dma_rd_a: assert property (dma_dack_i && dma_mem_write_i |=> !d_rd_n_o)
    else $error("DMA read strobe missing");
  dma_wr_a: assert property (dma_dack_i && !dma_mem_write_i |=> !d_wr_n_o)
    else $error("DMA write strobe missing");
  bus_req_a: assert property (bus_want_i |=> !br_n_o)
    else $error("bus request missing");
  grant_off_a: assert property (bg_n_i [*4] |=> !bus_granted_o)
    else $error("granted without grant");
  slow_len_a: assert property ($rose(d_cs_n_o) |->
    cs_cnt_ff == (slow_n_i ? STROBE_CNT : SLOW_CNT))
    else $error("D strobe length wrong");
endmodule : dsap_chk
bind dsap_top dsap_chk u_chk (.*);

//--- sim/dsap_periph.sv
// Far side model: D channel byte registers, E channel halfword
// registers and the optional PROM; assumes registered strobes.
`timescale 1ns/10ps
module dsap_periph #(
  parameter logic [7:0] PROM_BYTE = 8'h6e  // Arbitrary value
) (
  input  wire logic        clk_i,
  input  wire logic        cs_d_n_i,
  input  wire logic        rd_d_n_i,
  input  wire logic        wr_d_n_i,
  input  wire logic [7:0]  dd_i,
  input  wire logic        dd_oe_i,
  input  wire logic [3:1]  addr_i,
  input  wire logic        cs_e_n_i,
  input  wire logic        read_e_i,
  input  wire logic [15:0] e_ad_i,
  input  wire logic        e_ad_oe_i,
  input  wire logic        prom_sel_i,
  input  wire logic        prom_sel_oe_i,
  input  wire logic        prom_fit_i,
  input  wire logic        slow_req_i,
  output logic      [7:0]  dd_o,
  output logic      [15:0] e_ad_o,
  output logic             prom_pin_o,
  output logic             slow_n_o
);
  logic [7:0]  d_reg_ff [8];
  logic [15:0] e_reg_ff [8];
  logic [15:0] idle_ff = 16'h5aa5;
  wire logic d_rd = !rd_d_n_i && (!cs_d_n_i || prom_sel_oe_i);
  wire logic e_rd = !cs_e_n_i && read_e_i;
  // Released lines toggle so stale data cannot pass as a read
  always @(posedge clk_i) begin
    idle_ff <= ~idle_ff;
    if (!cs_d_n_i && !wr_d_n_i && dd_oe_i) d_reg_ff[addr_i] <= dd_i;
    if (!cs_e_n_i && !read_e_i && e_ad_oe_i) e_reg_ff[addr_i] <= e_ad_i;
  end
  assign dd_o = !d_rd ? idle_ff[7:0] :
    (prom_sel_oe_i ? PROM_BYTE : d_reg_ff[addr_i]);
  assign e_ad_o = e_rd ? e_reg_ff[addr_i] : idle_ff;
  assign prom_pin_o = prom_sel_oe_i ? prom_sel_i : prom_fit_i;
  assign slow_n_o = !slow_req_i;
endmodule : dsap_periph

//--- sim/tb_dma_slave_access_port.sv
// Self-checking bench: random traffic to all four targets, refusals,
// drain and side pins; assumes the checker and the far side model.
`timescale 1ns/10ps
`define CK(g, e) begin \
  n_compared++; \
  if ((g) !== (e)) begin \
    failures++; \
    $display("ERROR %0t: got %h want %h", $time, g, e); \
  end \
end
module tb_dma_slave_access_port;
  import dsap_pkg::*;
  localparam logic [31:0] ID_V   = 32'hc3a5_5a3c;  // Arbitrary value
  localparam logic [7:0]  PROM_B = 8'h6e;          // Arbitrary value
  logic clk_i = 1'b0, rst_n_i = 1'b0, sel_n_i = 1'b1, as_n_i = 1'b1;
  logic target_decode_hi_i = 1'b0, target_decode_lo_i = 1'b0, rd_i = 1'b1;
  logic [3:1] pa_i = 3'h0;
  logic [2:0] siz_i = 3'h0, ak;
  logic [31:0] d_i = 32'h0, rdat, w [4];
  logic bg_n_i = 1'b1, lerr_n_i = 1'b1, d_irq_n_i = 1'b1, d_req_i = 1'b0;
  logic pack_busy_d_i = 1'b0, pack_busy_e_i = 1'b0, bus_want_i = 1'b0;
  logic dma_dack_i = 1'b0, dma_mem_write_i = 1'b0, xfer_done_i = 1'b0;
  logic xfer_err_i = 1'b0, slow_req = 1'b0, prom_fit = 1'b0;
  logic [7:0] b [8];
  logic [15:0] h [8];
  int unpack_cnt = 0, failures = 0, n_compared = 0, i, k;
  wire logic unpack_valid_i = (unpack_cnt != 0);
  wire logic [31:0] d_o;
  wire logic [127:0] regs_o;
  wire logic [15:0] e_ad_i, e_ad_o;
  wire logic [7:0] dd_i, dd_o;
  wire logic [3:1] dch_addr_o;
  wire logic [2:0] ack_n_o;
  wire logic [1:0] late_err_tgt_o;
  wire logic d_oe_o, ack_oe_o, br_n_o, br_oe_o, bus_granted_o, intreq_n_o;
  wire logic intreq_oe_o, late_err_o, dd_oe_o, d_cs_n_o, d_rd_n_o, d_wr_n_o;
  wire logic d_irq_o, d_req_o, slow_n_i, prom_select_i, prom_select_o;
  wire logic prom_select_oe_o, prom_present_o, e_ad_oe_o, e_cs_n_o;
  wire logic e_read_o, unpack_pop_o;

  dsap_top #(.ID_VALUE(ID_V)) u_dut (.*);
  dsap_periph #(.PROM_BYTE(PROM_B)) u_periph (
    .clk_i(clk_i), .cs_d_n_i(d_cs_n_o), .rd_d_n_i(d_rd_n_o),
    .wr_d_n_i(d_wr_n_o), .dd_i(dd_o), .dd_oe_i(dd_oe_o),
    .addr_i(dch_addr_o), .cs_e_n_i(e_cs_n_o), .read_e_i(e_read_o),
    .e_ad_i(e_ad_o), .e_ad_oe_i(e_ad_oe_o), .prom_sel_i(prom_select_o),
    .prom_sel_oe_i(prom_select_oe_o), .prom_fit_i(prom_fit),
    .slow_req_i(slow_req), .dd_o(dd_i), .e_ad_o(e_ad_i),
    .prom_pin_o(prom_select_i), .slow_n_o(slow_n_i));

  initial forever #25 clk_i = ~clk_i;
  // Unpack register stand-in: empties one entry per pop
  always @(posedge clk_i) begin
    if (unpack_pop_o && unpack_cnt > 0) unpack_cnt <= unpack_cnt - 1;
  end
  //////////////////////////////////////////////////////////////////
  task automatic close_out;
    $display("Compared %0d, failures %0d", n_compared, failures);
    if (failures == 0 && n_compared > 0) begin
      $display("DONE - PASS");
    end else begin
      $display("DONE - FAIL");
    end
    $finish;
  endtask : close_out

  task automatic do_reset;
    @(negedge clk_i);
    rst_n_i = 1'b0;
    repeat (4) @(negedge clk_i);
    rst_n_i = 1'b1;
    repeat (3) @(negedge clk_i);
    `CK({ack_oe_o, ack_n_o}, {1'b0, ACK_IDLE})
    `CK({d_cs_n_o, d_rd_n_o, d_wr_n_o, e_cs_n_o}, 4'hf)
    `CK(regs_o, 128'h0)
    `CK(prom_present_o, prom_fit)
  endtask : do_reset

  // One slave cycle: held until the ack cycle, then released
  task automatic xa(input logic [1:0] tg, input logic r,
                    input logic [3:1] a, input logic [2:0] sz,
                    input logic [31:0] wd, input logic [2:0] eak,
                    input logic [31:0] ed);
    int n;
    @(negedge clk_i);
    {target_decode_hi_i, target_decode_lo_i} = tg;
    rd_i = r;
    pa_i = a;
    siz_i = sz;
    d_i = wd;
    sel_n_i = 1'b0;
    as_n_i = 1'b0;
    n = 0;
    while (ack_oe_o !== 1'b1 && n < 60) begin
      @(negedge clk_i);
      n++;
    end
    ak = ack_n_o;
    rdat = d_o;
    `CK(n < 60, 1'b1)
    if (n >= 60) close_out();
    `CK(ak, eak)
    `CK(d_oe_o, r && eak != ACK_RERUN)
    if (r && eak != ACK_ERR && eak != ACK_RERUN) `CK(rdat, ed)
    @(negedge clk_i);
    sel_n_i = 1'b1;
    as_n_i = 1'b1;
    d_i = ~wd;
    repeat (5) @(negedge clk_i);
  endtask : xa

  initial begin
    void'($urandom(60));
    do_reset();
    xa(TGT_ID, 1'b1, 3'h0, SIZ_WORD, 32'h0, ACK_WORD, ID_V);
    for (i = 0; i < 4; i++) begin
      w[i] = $urandom;
      xa(TGT_INT, 1'b0, 3'(i * 2), SIZ_WORD, w[i], ACK_WORD, 32'h0);
    end
    `CK(regs_o, {w[3], w[2], w[1], w[0]})
    // Odd PA[1]: word still chosen by PA[3:2]
    for (i = 0; i < 4; i++) begin
      xa(TGT_INT, 1'b1, 3'(i * 2 + 1), SIZ_WORD, 32'h0, ACK_WORD, w[i]);
    end
    for (i = 0; i < 8; i++) begin
      b[i] = 8'($urandom);
      h[i] = 16'($urandom);
      slow_req = 1'($urandom);
      xa(TGT_DCH, 1'b0, 3'(i), SIZ_BYTE, {b[i], 24'($urandom)},
         ACK_BYTE, 32'h0);
      xa(TGT_ECH, 1'b0, 3'(i), SIZ_HALF, {h[i], 16'($urandom)},
         ACK_HALF, 32'h0);
    end
    for (i = 0; i < 8; i++) begin
      slow_req = 1'($urandom);
      xa(TGT_DCH, 1'b1, 3'(i), SIZ_BYTE, 32'h0, ACK_BYTE, {4{b[i]}});
      xa(TGT_ECH, 1'b1, 3'(i), SIZ_HALF, 32'h0, ACK_HALF, {2{h[i]}});
    end
    xa(TGT_DCH, 1'b1, 3'h0, SIZ_WORD, 32'h0, ACK_ERR, 32'h0);
    xa(TGT_ECH, 1'b0, 3'h0, SIZ_BYTE, 32'h0, ACK_ERR, 32'h0);
    xa(TGT_ECH, 1'b1, 3'h0, SIZ_HALF, 32'h0, ACK_HALF, {2{h[0]}});
    pack_busy_d_i = 1'b1;
    xa(TGT_INT, 1'b1, 3'h0, SIZ_WORD, 32'h0, ACK_RERUN, 32'h0);
    pack_busy_d_i = 1'b0;
    pack_busy_e_i = 1'b1;
    xa(TGT_DCH, 1'b1, 3'h0, SIZ_BYTE, 32'h0, ACK_RERUN, 32'h0);
    pack_busy_e_i = 1'b0;
    unpack_cnt = 5;
    xa(TGT_INT, 1'b1, 3'h0, SIZ_WORD, 32'h0, ACK_WORD, w[0]);
    `CK(unpack_valid_i, 1'b0)
    {bus_want_i, bg_n_i, xfer_err_i, lerr_n_i} = 4'ha;
    {d_irq_n_i, d_req_i, dma_dack_i, dma_mem_write_i} = 4'h7;
    k = 0;
    repeat (6) begin
      @(negedge clk_i);
      if (late_err_o === 1'b1) k++;
    end
    `CK(k, 1)
    `CK(late_err_tgt_o, TGT_INT)
    `CK({br_n_o, bus_granted_o, intreq_oe_o, intreq_n_o}, 4'h6)
    `CK({d_irq_o, d_req_o, d_rd_n_o, d_wr_n_o}, 4'hd)
    {dma_mem_write_i, xfer_err_i, xfer_done_i} = 3'h1;
    repeat (2) @(negedge clk_i);
    `CK({d_rd_n_o, d_wr_n_o, intreq_oe_o}, 3'h5)
    {bus_want_i, bg_n_i, xfer_done_i, lerr_n_i} = 4'h5;
    {d_irq_n_i, d_req_i, dma_dack_i} = 3'h4;
    repeat (4) @(negedge clk_i);
    `CK({br_oe_o, br_n_o, bus_granted_o, intreq_oe_o}, 4'hc)
    prom_fit = 1'b1;
    do_reset();
    xa(TGT_ID, 1'b1, 3'h0, SIZ_BYTE, 32'h0, ACK_BYTE, {4{PROM_B}});
    close_out();
  end
endmodule : tb_dma_slave_access_port
